// ### lrs_pkg.sv
// Purpose: Constants for the logger clock, sample and result registers.
// Assumes: Byte registers at 0x200..0x20F, all values BCD where timekeeping.
// Notes:   Shared by the register block and its checks.
package lrs_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [15:0] A_SEC   = 16'h0200; // Seconds
	localparam logic [15:0] A_MIN   = 16'h0201; // Minutes
	localparam logic [15:0] A_HR    = 16'h0202; // Hours
	localparam logic [15:0] A_DATE  = 16'h0203; // Date
	localparam logic [15:0] A_MON   = 16'h0204; // Months and century
	localparam logic [15:0] A_YR    = 16'h0205; // Years
	localparam logic [15:0] A_SRL   = 16'h0206; // Interval low
	localparam logic [15:0] A_SRH   = 16'h0207; // Interval high
	localparam logic [15:0] A_TLTH  = 16'h0208; // Temp low threshold
	localparam logic [15:0] A_THTH  = 16'h0209; // Temp high threshold
	localparam logic [15:0] A_HLTH  = 16'h020A; // Humid low threshold
	localparam logic [15:0] A_HHTH  = 16'h020B; // Humid high threshold
	localparam logic [15:0] A_TRL   = 16'h020C; // Temp result low
	localparam logic [15:0] A_TRH   = 16'h020D; // Temp result high
	localparam logic [15:0] A_HRL   = 16'h020E; // Humid result low
	localparam logic [15:0] A_HRH   = 16'h020F; // Humid result high
	// ----------------------------------------
	// Writable bit masks (fixed zero cells cleared)
	// ----------------------------------------
	localparam logic [7:0]  M_SEC   = 8'h7F;
	localparam logic [7:0]  M_MIN   = 8'h7F;
	localparam logic [7:0]  M_HR    = 8'h7F;
	localparam logic [7:0]  M_DATE  = 8'h3F;
	localparam logic [7:0]  M_MON   = 8'h9F;
	localparam logic [7:0]  M_SRH   = 8'h3F;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int          HR_MODE = 6;        // 1 = 12-hour
	localparam int          HR_PM   = 5;        // Afternoon or 20-hour digit
	localparam int          MON_CEN = 7;        // Century flag
	// ----------------------------------------
	// BCD limits
	// ----------------------------------------
	localparam logic [7:0]  B_00    = 8'h00;
	localparam logic [7:0]  B_01    = 8'h01;
	localparam logic [7:0]  B_02    = 8'h02;
	localparam logic [7:0]  B_04    = 8'h04;
	localparam logic [7:0]  B_06    = 8'h06;
	localparam logic [7:0]  B_09    = 8'h09;
	localparam logic [7:0]  B_11    = 8'h11;
	localparam logic [7:0]  B_12    = 8'h12;
	localparam logic [7:0]  B_23    = 8'h23;
	localparam logic [7:0]  B_28    = 8'h28;
	localparam logic [7:0]  B_29    = 8'h29;
	localparam logic [7:0]  B_30    = 8'h30;
	localparam logic [7:0]  B_31    = 8'h31;
	localparam logic [7:0]  B_59    = 8'h59;
	localparam logic [7:0]  B_99    = 8'h99;
	localparam logic [3:0]  U_9     = 4'h9;
	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [13:0] SR_MIN  = 14'h0001; // Smallest interval
	localparam logic [5:0]  SEC_TOP = 6'h3B;    // Last second of a minute
	localparam logic [15:0] T_COLD  = 16'h0000; // Too-cold code
	localparam logic [15:0] T_HOT   = 16'hFFE0; // Too-hot code
endpackage : lrs_pkg

// ### lrs_regs.sv
// Purpose: Clock, calendar, sample interval, thresholds and latest results.
// Assumes: sec_tick is a one-cycle pulse per second from the RTC side.
// Notes:   Register access is a plain byte port behind the serial bus.
`timescale 1ns/100ps

module lrs_regs (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// Timebase and mission
	input  wire logic        sec_tick,
	input  wire logic        mission_active,
	input  wire logic        sample_unit_select,
	input  wire logic        temp_log_width_select,
	input  wire logic        humid_log_width_select,
	// Register port
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Conversion results
	input  wire logic        temp_valid,
	input  wire logic [10:0] temp_code,
	input  wire logic        temp_too_cold,
	input  wire logic        temp_too_hot,
	input  wire logic        humid_valid,
	input  wire logic [15:0] humid_word,
	// Alarms
	input  wire logic        temp_high_alarm_enable,
	input  wire logic        temp_low_alarm_enable,
	input  wire logic        humid_high_alarm_enable,
	input  wire logic        humid_low_alarm_enable,
	input  wire logic        alarm_clear,
	output logic             temp_high_alarm_flag,
	output logic             temp_low_alarm_flag,
	output logic             humid_high_alarm_flag,
	output logic             humid_low_alarm_flag,
	// Logging
	output logic             sample_due,
	output logic             humid_log_low_byte
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]  sec;     // BCD seconds
		logic [7:0]  min;     // BCD minutes
		logic [7:0]  hr;      // Mode, PM/20h, BCD hours
		logic [7:0]  date;    // BCD date
		logic [7:0]  mon;     // Century and BCD month
		logic [7:0]  yr;      // BCD year
		logic [13:0] ivl;     // Sample interval
		logic [7:0]  tlth;    // Temp low threshold
		logic [7:0]  thth;    // Temp high threshold
		logic [7:0]  hlth;    // Humid low threshold
		logic [7:0]  hhth;    // Humid high threshold
		logic [15:0] tres;    // Latest temperature
		logic [15:0] hres;    // Latest humidity
		logic [13:0] icnt;    // Interval units elapsed
		logic [5:0]  pre;     // Seconds within minute
		logic [3:0]  flag;    // HH, HL, TH, TL
		logic [7:0]  rdata;   // Read data
		logic        due;     // Sample event pulse
	} lrs_state_s;

	lrs_state_s s;            // Registered state
	lrs_state_s next_s;       // Next state
	lrs_state_s rst_s;        // Reset value

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// BCD increment of a two-digit value
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == lrs_pkg::U_9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = v + 8'h01;
		end
	endfunction : bcd_inc

	// Last date of a month; leap test on BCD year digits
	function automatic logic [7:0] last_day(input logic [4:0] m,
		input logic [7:0] y);
		logic leap;
		// Divisible by four: even tens with 0/4/8, odd tens with 2/6
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
			(y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case ({3'h0, m})
			lrs_pkg::B_02: last_day = leap ? lrs_pkg::B_29
				: lrs_pkg::B_28;
			lrs_pkg::B_04, lrs_pkg::B_06, lrs_pkg::B_09,
			lrs_pkg::B_11: last_day = lrs_pkg::B_30;
			default: last_day = lrs_pkg::B_31;
		endcase
	endfunction : last_day

	// ----------------------------------------
	// Reset image
	// ----------------------------------------
	always_comb begin
		rst_s      = '0;
		rst_s.date = lrs_pkg::B_01;
		rst_s.mon  = lrs_pkg::B_01;
		rst_s.ivl  = lrs_pkg::SR_MIN;
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	// Order: ticks and results first, host writes last so they win.
	always_comb begin
		logic       day_c;
		logic       min_w;
		logic       unit_t;
		logic [7:0] hv;
		logic [7:0] hn;
		logic [7:0] wd;
		logic [7:0] rd;
		day_c  = 1'b0;
		min_w  = 1'b0;
		unit_t = 1'b0;
		hv     = '0;
		hn     = '0;
		wd     = reg_wdata;
		rd     = '0;
		next_s = s;
		next_s.due = 1'b0;
		// Clock chain, one step per second
		if (sec_tick) begin
			if (s.sec == lrs_pkg::B_59) begin
				next_s.sec = lrs_pkg::B_00;
				if (s.min == lrs_pkg::B_59) begin
					next_s.min = lrs_pkg::B_00;
					if (s.hr[lrs_pkg::HR_MODE]) begin
						// 12-hour: 11 to 12 flips afternoon, 12 to 01
						hv = {3'h0, s.hr[4:0]};
						if (hv == lrs_pkg::B_12) begin
							next_s.hr[4:0] = lrs_pkg::B_01[4:0];
						end else if (hv == lrs_pkg::B_11) begin
							next_s.hr[4:0] = lrs_pkg::B_12[4:0];
							next_s.hr[lrs_pkg::HR_PM] = ~s.hr[lrs_pkg::HR_PM];
							day_c = s.hr[lrs_pkg::HR_PM];
						end else begin
							hn = bcd_inc(hv);
							next_s.hr[4:0] = hn[4:0];
						end
					end else begin
						// 24-hour: bit 5 is the twenty digit
						hv = {2'h0, s.hr[5:0]};
						if (hv == lrs_pkg::B_23) begin
							next_s.hr[5:0] = 6'h00;
							day_c = 1'b1;
						end else begin
							hn = bcd_inc(hv);
							next_s.hr[5:0] = hn[5:0];
						end
					end
				end else begin
					next_s.min = bcd_inc(s.min);
				end
			end else begin
				next_s.sec = bcd_inc(s.sec);
			end
		end
		// Calendar carry
		if (day_c) begin
			if (s.date == last_day(s.mon[4:0], s.yr)) begin
				next_s.date = lrs_pkg::B_01;
				if (s.mon[4:0] == lrs_pkg::B_12[4:0]) begin
					next_s.mon[4:0] = lrs_pkg::B_01[4:0];
					if (s.yr == lrs_pkg::B_99) begin
						next_s.yr = lrs_pkg::B_00;
						next_s.mon[lrs_pkg::MON_CEN] = ~s.mon[lrs_pkg::MON_CEN];
					end else begin
						next_s.yr = bcd_inc(s.yr);
					end
				end else begin
					hn = bcd_inc({3'h0, s.mon[4:0]});
					next_s.mon[4:0] = hn[4:0];
				end
			end else begin
				next_s.date = bcd_inc(s.date);
			end
		end
		// Minute prescaler runs always so minute units stay aligned
		if (sec_tick) begin
			if (s.pre == lrs_pkg::SEC_TOP) begin
				next_s.pre = '0;
				min_w = 1'b1;
			end else begin
				next_s.pre = s.pre + 6'h01;
			end
		end
		// Sample interval counter
		unit_t = sample_unit_select ? sec_tick : min_w;
		if (!mission_active) begin
			next_s.icnt = '0;
		end else if (unit_t) begin
			if (s.icnt + 14'h0001 >= s.ivl) begin
				next_s.icnt = '0;
				next_s.due  = 1'b1;
			end else begin
				next_s.icnt = s.icnt + 14'h0001;
			end
		end
		// Latest temperature, same code as logged entries
		if (temp_valid) begin
			if (temp_too_cold) begin
				next_s.tres = lrs_pkg::T_COLD;
			end else if (temp_too_hot) begin
				next_s.tres = lrs_pkg::T_HOT;
			end else begin
				// High byte is half degrees, top three low bits are sixteenths
				next_s.tres = {temp_code, 5'h00};
				if (!temp_log_width_select) begin
					next_s.tres[7:0] = 8'h00;
				end
			end
		end
		// Latest humidity, full word whatever the format
		if (humid_valid) begin
			next_s.hres = humid_word;
		end
		// Alarm flags, high byte only; set wins over clear
		if (alarm_clear) begin
			next_s.flag = '0;
		end
		if (mission_active && temp_valid) begin
			if (temp_high_alarm_enable && next_s.tres[15:8] >= s.thth) begin
				next_s.flag[1] = 1'b1;
			end
			if (temp_low_alarm_enable && next_s.tres[15:8] <= s.tlth) begin
				next_s.flag[0] = 1'b1;
			end
		end
		if (mission_active && humid_valid) begin
			if (humid_high_alarm_enable && humid_word[15:8] >= s.hhth) begin
				next_s.flag[3] = 1'b1;
			end
			if (humid_low_alarm_enable && humid_word[15:8] <= s.hlth) begin
				next_s.flag[2] = 1'b1;
			end
		end
		// Host writes, read-only while a mission runs
		if (reg_wr && !mission_active) begin
			case (reg_addr)
				lrs_pkg::A_SEC:  next_s.sec  = wd & lrs_pkg::M_SEC;
				lrs_pkg::A_MIN:  next_s.min  = wd & lrs_pkg::M_MIN;
				lrs_pkg::A_HR:   next_s.hr   = wd & lrs_pkg::M_HR;
				lrs_pkg::A_DATE: next_s.date = wd & lrs_pkg::M_DATE;
				lrs_pkg::A_MON:  next_s.mon  = wd & lrs_pkg::M_MON;
				lrs_pkg::A_YR:   next_s.yr   = wd;
				lrs_pkg::A_SRL:  next_s.ivl[7:0] = wd;
				lrs_pkg::A_SRH:  next_s.ivl[13:8] = wd[5:0];
				lrs_pkg::A_TLTH: next_s.tlth = wd;
				lrs_pkg::A_THTH: next_s.thth = wd;
				lrs_pkg::A_HLTH: next_s.hlth = wd;
				lrs_pkg::A_HHTH: next_s.hhth = wd;
				default: next_s.rdata = next_s.rdata;
			endcase
			// Zero interval is kept as one unit
			if (next_s.ivl == '0) begin
				next_s.ivl = lrs_pkg::SR_MIN;
			end
		end
		// Read mux; unmapped addresses read zero
		case (reg_addr)
			lrs_pkg::A_SEC:  rd = s.sec;
			lrs_pkg::A_MIN:  rd = s.min;
			lrs_pkg::A_HR:   rd = s.hr;
			lrs_pkg::A_DATE: rd = s.date;
			lrs_pkg::A_MON:  rd = s.mon;
			lrs_pkg::A_YR:   rd = s.yr;
			lrs_pkg::A_SRL:  rd = s.ivl[7:0];
			lrs_pkg::A_SRH:  rd = {2'h0, s.ivl[13:8]};
			lrs_pkg::A_TLTH: rd = s.tlth;
			lrs_pkg::A_THTH: rd = s.thth;
			lrs_pkg::A_HLTH: rd = s.hlth;
			lrs_pkg::A_HHTH: rd = s.hhth;
			lrs_pkg::A_TRL:  rd = s.tres[7:0];
			lrs_pkg::A_TRH:  rd = s.tres[15:8];
			lrs_pkg::A_HRL:  rd = s.hres[7:0];
			lrs_pkg::A_HRH:  rd = s.hres[15:8];
			default:         rd = 8'h00;
		endcase
		// Clock bytes are not snapshotted; coherence is up to the host burst
		if (reg_rd) begin
			next_s.rdata = rd;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// The enable freezes everything, including the read latch
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s <= rst_s;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata             = s.rdata;
	assign temp_low_alarm_flag   = s.flag[0];
	assign temp_high_alarm_flag  = s.flag[1];
	assign humid_low_alarm_flag  = s.flag[2];
	assign humid_high_alarm_flag = s.flag[3];
	assign sample_due            = s.due;
	// Low humidity byte is logged only in 16-bit format
	assign humid_log_low_byte    = mission_active && humid_log_width_select;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// Write of a zero interval low byte with zero high byte
	sequence zero_ivl_wr;
		ce && reg_wr && !mission_active && reg_addr == lrs_pkg::A_SRL
			&& reg_wdata == 8'h00 && s.ivl[13:8] == 6'h00;
	endsequence

	fixed_zero_a: assert property (ce && reg_rd && reg_addr == lrs_pkg::A_SEC
		|=> reg_rdata[7] == 1'b0) else $error("seconds bit 7 not zero");
	// Host may store any byte; only the counting itself must keep digits legal
	bcd_digit_a: assert property (ce && !reg_wr && s.sec[3:0] <= lrs_pkg::U_9
		&& s.min[3:0] <= lrs_pkg::U_9 |=> s.sec[3:0] <= lrs_pkg::U_9
		&& s.min[3:0] <= lrs_pkg::U_9) else $error("clock digit out of BCD range");
	mission_lock_a: assert property (ce && mission_active && reg_wr
		&& reg_addr == lrs_pkg::A_SEC && !sec_tick |=> $stable(s.sec))
		else $error("seconds written during mission");
	zero_ivl_a: assert property (zero_ivl_wr |=> s.ivl == lrs_pkg::SR_MIN)
		else $error("zero interval not stored as one");
	ivl_nonzero_a: assert property (s.ivl != 14'h0000)
		else $error("interval is zero");
	too_hot_a: assert property (ce && temp_valid && !temp_too_cold
		&& temp_too_hot |=> s.tres == lrs_pkg::T_HOT) else $error("too-hot code wrong");
	temp_high_a: assert property (ce && mission_active && temp_valid
		&& !temp_too_cold && !temp_too_hot && temp_high_alarm_enable
		&& temp_code[10:3] >= s.thth |=> temp_high_alarm_flag)
		else $error("temp high alarm missed");
	// A host write in the rollover cycle wins, so only plain carries are judged
	century_flip_a: assert property (ce && !$past(reg_wr)
		&& $past(s.yr) == lrs_pkg::B_99 && s.yr == lrs_pkg::B_00
		|-> s.mon[7] != $past(s.mon[7])) else $error("century flag did not flip");
	sample_mission_a: assert property (sample_due |-> $past(mission_active))
		else $error("sample event outside mission");
endmodule : lrs_regs

// ### lrs_host.sv
// Purpose: Host reader model driving the register byte port.
// Assumes: One access at a time, launched just after a rising edge.
// Notes:   Idle lines carry inverted last values, never a stale copy.
`timescale 1ns/100ps
module lrs_host (
	// Clock
	input  wire logic        clock,
	// Register port
	output logic      [15:0] reg_addr,
	output logic             reg_wr,
	output logic      [7:0]  reg_wdata,
	output logic             reg_rd,
	input  wire logic [7:0]  reg_rdata
);
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	// Quiet bus at time zero
	initial begin
		reg_addr  = 16'h0000;
		reg_wr    = 1'b0;
		reg_wdata = 8'h00;
		reg_rd    = 1'b0;
	end
	// One write strobe; lines scrambled after so nothing leans on old data
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	// Read strobe taken at the next edge; data settles just after it
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask : rd
	// Clock bytes in one pass from the first address, for a coherent snapshot
	task automatic burst(output logic [7:0] q [6]);
		for (int i = 0; i < 6; i++) begin
			rd(16'h0200 + 16'(i), q[i]);
		end
	endtask : burst
	// Temperature threshold byte from twice the degrees
	function automatic logic [7:0] temp_threshold_code(input int deg2);
		return 8'(deg2) + 8'h52;
	endfunction : temp_threshold_code
endmodule : lrs_host

// ### logger_rtc_sample_result_regs_tb.sv
// Purpose: Self-checking bench for the logger clock and result registers.
// Assumes: One-cycle register port and pulse timing of the design.
// Notes:   An integer model of fields predicts each byte read back; fixed-zero and unmapped reads use constants.
`timescale 1ns/100ps
module logger_rtc_sample_result_regs_tb;
	// ----------------------------------------
	// Design signals
	// ----------------------------------------
	logic        clock = 1'b0;             // 25 ns period
	logic        rst_n = 1'b0;             // Held low at start
	logic        ce = 1'b1;                // Timebase always enabled
	logic        sec_tick = 1'b0;
	logic        mission_active = 1'b0;
	logic        sample_unit_select = 1'b1;
	logic        temp_log_width_select = 1'b1;
	logic        humid_log_width_select = 1'b0;
	logic        temp_valid = 1'b0;
	logic        humid_valid = 1'b0;
	logic        temp_too_cold = 1'b0;
	logic        temp_too_hot = 1'b0;
	logic        alarm_clear = 1'b0;
	logic [3:0]  alarm_en = 4'h0;          // Temp low/high, humid low/high
	logic [10:0] temp_code = 11'h000;
	logic [15:0] humid_word = 16'h0000;
	logic [15:0] reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic [7:0]  v;
	logic [3:0]  flag;                     // Same order as alarm_en
	logic        sample_due;
	logic        humid_log_low_byte;
	logic [7:0]  q [6];
	logic [7:0]  fz [8] = '{8'h7F, 8'h7F, 8'h7F, 8'h3F, 8'h9F, 8'hFF, 8'hFF, 8'h3F};
	// ----------------------------------------
	// Model state
	// ----------------------------------------
	int s = 0, mi = 0, h = 0, pm = 0, md = 0, d = 1, mo = 1, y = 0, century_flag = 0;
	int ivl = 1, tr = 0, hr = 0, n = 0;
	int th [4] = '{0, 0, 0, 0};
	int fl [4] = '{0, 0, 0, 0};
	int err_total = 0;
	int checks_done = 0;

	lrs_regs DUT (
		.clock(clock), .rst_n(rst_n), .ce(ce), .sec_tick(sec_tick),
		.mission_active(mission_active), .sample_unit_select(sample_unit_select),
		.temp_log_width_select(temp_log_width_select),
		.humid_log_width_select(humid_log_width_select),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .temp_valid(temp_valid), .temp_code(temp_code),
		.temp_too_cold(temp_too_cold), .temp_too_hot(temp_too_hot),
		.humid_valid(humid_valid), .humid_word(humid_word),
		.temp_low_alarm_enable(alarm_en[0]), .temp_high_alarm_enable(alarm_en[1]),
		.humid_low_alarm_enable(alarm_en[2]), .humid_high_alarm_enable(alarm_en[3]),
		.alarm_clear(alarm_clear), .temp_low_alarm_flag(flag[0]),
		.temp_high_alarm_flag(flag[1]), .humid_low_alarm_flag(flag[2]),
		.humid_high_alarm_flag(flag[3]), .sample_due(sample_due),
		.humid_log_low_byte(humid_log_low_byte));
	lrs_host host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	// Free-running bench clock
	always #12.5 clock = ~clock;
	// ----------------------------------------
	// Model functions and checks
	// ----------------------------------------
	function automatic int bcd(input int x);
		return (x / 10) * 16 + x % 10;
	endfunction : bcd
	// Days in the current month; leap test valid for two-digit years only
	function automatic int dim();
		if (mo == 2) return (y % 4 == 0) ? 29 : 28;
		return (mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
	endfunction : dim
	// Expected byte at offset i from 0x200
	function automatic int exp_reg(input int i);
		case (i)
			0: return bcd(s);
			1: return bcd(mi);
			2: return md * 64 + pm * 32 + bcd(h);
			3: return bcd(d);
			4: return century_flag * 128 + bcd(mo);
			5: return bcd(y);
			6: return ivl % 256;
			7: return ivl / 256;
			12: return tr % 256;
			13: return tr / 256;
			14: return hr % 256;
			15: return hr / 256;
			default: return th[i - 8];
		endcase
	endfunction : exp_reg
	// Day carry through month, year and century
	function automatic void day_up();
		d = d % dim() + 1;
		if (d == 1) mo = mo % 12 + 1;
		if (d == 1 && mo == 1) y = (y + 1) % 100;
		if (d == 1 && mo == 1 && y == 0) century_flag = 1 - century_flag;
	endfunction : day_up
	// Alarm flags are sticky and only armed in a mission
	function automatic void alarm(input int k, input bit hit);
		if (mission_active === 1'b1 && alarm_en[k] === 1'b1 && hit) fl[k] = 1;
	endfunction : alarm
	task automatic cmp_byte(input string what, input int e, input logic [7:0] got,
		input logic [7:0] msk = 8'hFF);
		checks_done++;
		if ((got & msk) !== (8'(e) & msk)) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, 8'(e) & msk, got);
		end
	endtask : cmp_byte
	task automatic cmp_bit(input string what, input int e, input logic got);
		checks_done++;
		if (got !== 1'(e)) begin
			err_total++;
			$display("MISMATCH %s expected %0d seen %b", what, e, got);
		end
	endtask : cmp_bit
	task automatic chk(input int i, input logic [7:0] msk = 8'hFF);
		logic [7:0] r;
		host.rd(16'h0200 + 16'(i), r);
		cmp_byte($sformatf("reg %0h", 16'h0200 + i), exp_reg(i), r, msk);
	endtask : chk
	task automatic chk_fl();
		#1;
		for (int k = 0; k < 4; k++) cmp_bit("alarm flag", fl[k], flag[k]);
	endtask : chk_fl
	task automatic chk_clk();
		host.burst(q);
		for (int i = 0; i < 6; i++) cmp_byte("clock", exp_reg(i), q[i]);
	endtask : chk_clk
	// Host write, mirrored in the model for interval and threshold offsets outside a mission
	task automatic wr(input int i, input int x);
		host.wr(16'h0200 + 16'(i), 8'(x));
		if (mission_active === 1'b0 && i >= 6 && i <= 11) begin
			if (i == 6) ivl = ivl / 256 * 256 + x;
			if (i == 7) ivl = (x % 64) * 256 + ivl % 256;
			if (ivl == 0) ivl = 1;
			if (i > 7) th[i - 8] = x;
		end
	endtask : wr
	// One-second pulse, with the model's carry chain
	task automatic tick();
		@(posedge clock);
		sec_tick <= 1'b1;
		@(posedge clock);
		sec_tick <= 1'b0;
		s = (s + 1) % 60;
		if (s == 0) mi = (mi + 1) % 60;
		if (s != 0 || mi != 0) return;
		h = (md == 0) ? (h + 1) % 24 : h % 12 + 1;
		if (md == 1 && h == 12) pm = 1 - pm;
		if ((md == 0 && h == 0) || (md == 1 && h == 12 && pm == 0)) day_up();
	endtask : tick
	// Load a time one second before an hour change, tick, read back
	task automatic set_clk(input int nmd, nh, npm, nd, nmo, ny, nc);
		md = nmd; h = nh; pm = npm; mi = 59; s = 59; d = nd; mo = nmo; y = ny; century_flag = nc;
		for (int i = 0; i < 6; i++) host.wr(16'h0200 + 16'(i), 8'(exp_reg(i)));
		tick();
		chk_clk();
	endtask : set_clk
	task automatic conv_t(input logic [10:0] c, input logic cold, hot);
		@(posedge clock);
		temp_valid <= 1'b1;
		temp_code <= c;
		temp_too_cold <= cold;
		temp_too_hot <= hot;
		@(posedge clock);
		temp_valid <= 1'b0;
		tr = cold ? 0 : (hot ? 16'hFFE0 : 32 * int'(c));
		// 8-bit format keeps only the high byte of an in-range code
		if (!temp_log_width_select && !cold && !hot) tr -= tr % 256;
		alarm(0, tr / 256 <= th[0]);
		alarm(1, tr / 256 >= th[1]);
		chk_fl();
		chk(13);
		chk(12);
	endtask : conv_t
	task automatic conv_h(input logic [15:0] w);
		@(posedge clock);
		humid_valid <= 1'b1;
		humid_word <= w;
		@(posedge clock);
		humid_valid <= 1'b0;
		hr = int'(w);
		alarm(2, hr / 256 <= th[2]);
		alarm(3, hr / 256 >= th[3]);
		chk_fl();
		chk(15);
		chk(14, 8'hF0);
	endtask : conv_h
	task automatic clr();
		@(posedge clock);
		alarm_clear <= 1'b1;
		@(posedge clock);
		alarm_clear <= 1'b0;
		fl = '{0, 0, 0, 0};
		chk_fl();
	endtask : clr
	task automatic close_out();
		if (err_total == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	// Hang guard: a run this long means a stuck sequence
	initial begin
		repeat (60000) @(posedge clock);
		err_total++;
		close_out();
	end
	initial begin
		void'($urandom(78));
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		for (int i = 0; i < 16; i++) chk(i);
		host.rd(16'h0210, v);
		cmp_byte("unmapped", 0, v);
		// Fixed-zero cells refuse ones
		for (int i = 0; i < 8; i++) host.wr(16'h0200 + 16'(i), 8'hFF);
		// Read-back of all ones shows exactly the writable cells
		for (int i = 0; i < 8; i++) begin
			host.rd(16'h0200 + 16'(i), v);
			cmp_byte("fixed zero", fz[i], v);
		end
		ivl = 16383;
		wr(7, 0);
		wr(6, 0);
		chk(6);
		chk(7);
		wr(6, 2);
		wr(8, host.temp_threshold_code(-20));
		wr(9, host.temp_threshold_code(51));
		wr(10, 8'h58);
		wr(11, 8'h97);
		for (int i = 6; i < 12; i++) chk(i);
		set_clk(0, 23, 0, 28, 2, 4, 0);
		set_clk(0, 23, 0, 28, 2, 3, 1);
		set_clk(1, 11, 1, 31, 12, 99, 1);
		set_clk(1, 11, 1, 28, 2, 0, 0);
		set_clk(1, 11, 0, 30, 4, 0, 0);
		set_clk(0, 19, 0, 30, 6, 10, 0);
		// Results outside a mission never raise flags
		for (int i = 0; i < 4; i++) conv_t(11'($urandom), 1'b0, 1'b0);
		conv_t(11'h7FF, 1'b1, 1'b0);
		conv_t(11'h000, 1'b0, 1'b1);
		temp_log_width_select <= 1'b0;
		conv_t(11'($urandom), 1'b0, 1'b0);
		for (int i = 0; i < 3; i++) conv_h(16'($urandom));
		// Mission: writes locked, sampling and alarms live
		@(posedge clock);
		mission_active <= 1'b1;
		humid_log_width_select <= 1'b1;
		alarm_en <= 4'hF;
		#1 cmp_bit("log low byte", 1, humid_log_low_byte);
		host.wr(16'h0200, 8'h33);
		wr(6, 9);
		wr(9, 8'h10);
		chk(0);
		chk(6);
		chk(9);
		for (int k = 1; k <= 4; k++) begin
			tick();
			#1 cmp_bit("sample due", k % 2 == 0, sample_due);
		end
		sample_unit_select <= 1'b0;
		for (int k = 0; k < 240; k++) begin
			tick();
			#1 n += int'(sample_due === 1'b1);
		end
		cmp_byte("minute samples", 2, 8'(n));
		conv_t(11'h420, 1'b0, 1'b0);
		conv_t(11'h428, 1'b0, 1'b0);
		clr();
		conv_t(11'h1F0, 1'b0, 1'b0);
		conv_h(16'h5800);
		conv_h(16'h9700);
		clr();
		alarm_en <= 4'h0;
		conv_t(11'h000, 1'b0, 1'b1);
		mission_active <= 1'b0;
		@(posedge clock);
		#1 cmp_bit("log low byte", 0, humid_log_low_byte);
		chk_clk();
		close_out();
	end
endmodule : logger_rtc_sample_result_regs_tb
